// File: acp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module acp_ctrl #(
    parameter bit LARGE_PKG = 1'b1                        // All 13 inputs present
) (
    input  wire logic               clk_sys,              // System clock
    input  wire logic               rst,                  // Async reset, high
    input  wire acp_pkg::acp_bus_t  bus_i,                // Register request
    output var  logic [7:0]         rd_data,              // Read data, next cycle
    input  wire logic               fuse_pin,             // Analog-default fuse
    input  wire logic               core_done,            // Core finished, pulse
    input  wire logic [9:0]         core_result,          // Core result
    output var  acp_pkg::acp_core_t core_o,               // Core controls
    output var  logic [12:0]        pin_analog_mask       // One = analog pin
);
    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    typedef struct packed {
        acp_pkg::acp_state_t state;                       // Sequencer state
        logic               cal;                          // calibrate_next
        logic [3:0]         chs;                          // channel_select
        logic               go;                           // Busy bit
        logic               on;                           // converter_on
        logic               nref;                         // neg_ref_select
        logic               pref;                         // pos_ref_select
        logic [3:0]         pcfg;                         // pin_analog_config
        logic               just;                         // result_justify
        logic [2:0]         acqt;                         // acquisition_time_select
        logic [2:0]         adcs;                         // Bit period select
        logic [9:0]         result;                       // Raw result
        logic               done;                         // conversion_done_flag
        logic [6:0]         tad_cnt;                      // Bit period counter
        logic [4:0]         acq_cnt;                      // Periods left
        logic [1:0]         fuse_cnt;                     // Fuse load wait
        logic               fuse_ld;                      // Fuse value taken
        logic               sync1;                        // Fuse sync stage 1
        logic               sync2;                        // Fuse sync stage 2
        logic [7:0]         rd;                           // Read data
        acp_pkg::acp_core_t core;                         // Core controls
        logic [12:0]        mask;                         // Analog pin mask
    } acp_st_t;

    acp_st_t st_r;                                        // Registered state
    acp_st_t st_nxt;                                      // Next state

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    // Acquisition length in bit periods
    function automatic logic [4:0] acq_periods(input logic [2:0] c);
        unique case (c)
            3'h0: acq_periods = 5'h00;
            3'h1: acq_periods = 5'h02;
            3'h2: acq_periods = 5'h04;
            3'h3: acq_periods = 5'h06;
            3'h4: acq_periods = 5'h08;
            3'h5: acq_periods = 5'h0C;
            3'h6: acq_periods = 5'h10;
            3'h7: acq_periods = 5'h14;
        endcase
    endfunction

    // System clocks per bit period
    function automatic logic [6:0] tad_cycles(input logic [2:0] c);
        unique case (c)
            3'h0: tad_cycles = 7'h02;
            3'h1: tad_cycles = 7'h08;
            3'h2: tad_cycles = 7'h20;
            3'h4: tad_cycles = 7'h04;
            3'h5: tad_cycles = 7'h10;
            3'h6: tad_cycles = 7'h40;
            default: tad_cycles = acp_pkg::FRC_CYC;       // RC clock codes
        endcase
    endfunction

    // Analog pins for a pin field code
    function automatic logic [12:0] pin_mask(input logic [3:0] c);
        logic [12:0] m;
        m = 13'h1FFF;
        if (c > acp_pkg::PCFG_ALLA) begin
            m = m >> (c - acp_pkg::PCFG_ALLA);            // RL13
        end
        if (!LARGE_PKG) begin
            m[7:5] = 3'h0;                                // RL5
        end
        return m;
    endfunction

    // Channel code routes a real input
    function automatic logic ch_exists(input logic [3:0] c);
        logic ok;
        ok = (c <= acp_pkg::CH_LAST);                     // RL3 RL4
        if (!LARGE_PKG && c >= 4'h5 && c <= 4'h7) begin
            ok = 1'b0;                                    // RL5
        end
        return ok;
    endfunction

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb begin
        logic start;
        logic [4:0] acq;
        start  = 1'b0;
        acq    = 5'h00;
        st_nxt = st_r;
        st_nxt.core.start = 1'b0;
        st_nxt.rd = 8'h00;
        // Fuse synchroniser and one-time load after reset
        st_nxt.sync1 = fuse_pin;
        st_nxt.sync2 = st_r.sync1;
        if (!st_r.fuse_ld) begin
            st_nxt.fuse_cnt = st_r.fuse_cnt + 2'h1;
            if (st_r.fuse_cnt == acp_pkg::FUSE_WAIT) begin
                st_nxt.fuse_ld = 1'b1;
                st_nxt.pcfg = st_r.sync2 ? acp_pkg::PCFG_FUSE1
                                         : acp_pkg::PCFG_FUSE0; // RL14
            end
        end
        // Register writes
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                acp_pkg::OFS_CTRL0: begin
                    st_nxt.cal = bus_i.wdata[acp_pkg::B_CAL]; // RL6
                    st_nxt.chs = bus_i.wdata[5:2];            // RL3
                    st_nxt.on  = bus_i.wdata[acp_pkg::B_ON];  // RL7
                    // Start only when enabled and idle
                    start = bus_i.wdata[acp_pkg::B_GO] && bus_i.wdata[acp_pkg::B_ON]
                            && st_r.state == acp_pkg::ACP_IDLE; // RL19
                end
                acp_pkg::OFS_PINREF: begin
                    st_nxt.nref = bus_i.wdata[acp_pkg::B_NREF]; // RL10
                    st_nxt.pref = bus_i.wdata[acp_pkg::B_PREF]; // RL11
                    st_nxt.pcfg = bus_i.wdata[3:0];             // RL13
                end
                acp_pkg::OFS_TIMING: begin
                    st_nxt.just = bus_i.wdata[acp_pkg::B_JUST]; // RL17
                    st_nxt.acqt = bus_i.wdata[5:3];
                    st_nxt.adcs = bus_i.wdata[2:0];
                end
                acp_pkg::OFS_STATUS: begin
                    // Write one clears the done flag
                    if (bus_i.wdata[0]) begin
                        st_nxt.done = 1'b0;
                    end
                end
                default: begin
                    // Result and unmapped: ignored
                end
            endcase
        end
        // Sequencer
        unique case (st_r.state)
            acp_pkg::ACP_IDLE: begin
                if (start) begin
                    // Settings captured at start
                    st_nxt.go = 1'b1;                      // RL8
                    st_nxt.core.calibrate   = st_nxt.cal;  // RL6
                    st_nxt.core.channel     = st_nxt.chs;  // RL20
                    st_nxt.core.ch_valid    = ch_exists(st_nxt.chs); // RL4
                    st_nxt.core.neg_ref_ext = st_r.nref;   // RL10
                    st_nxt.core.pos_ref_ext = st_r.pref;   // RL11
                    acq = acq_periods(st_r.acqt);
                    if (acq == 5'h00) begin
                        st_nxt.core.start = 1'b1;          // RL16
                        st_nxt.state = acp_pkg::ACP_CONV;
                    end else begin
                        st_nxt.acq_cnt = acq;              // RL16
                        st_nxt.tad_cnt = tad_cycles(st_r.adcs);
                        st_nxt.state = acp_pkg::ACP_ACQ;
                    end
                end
            end
            acp_pkg::ACP_ACQ: begin
                // Count bit periods, then convert
                if (st_r.tad_cnt > 7'h1) begin
                    st_nxt.tad_cnt = st_r.tad_cnt - 7'h1;
                end else if (st_r.acq_cnt > 5'h1) begin
                    st_nxt.acq_cnt = st_r.acq_cnt - 5'h1;
                    st_nxt.tad_cnt = tad_cycles(st_r.adcs);
                end else begin
                    st_nxt.core.start = 1'b1;              // RL16
                    st_nxt.state = acp_pkg::ACP_CONV;
                end
            end
            acp_pkg::ACP_CONV: begin
                if (core_done) begin
                    st_nxt.result = core_result;           // RL1 RL15
                    st_nxt.go     = 1'b0;                  // RL15
                    st_nxt.done   = 1'b1;                  // RL15
                    st_nxt.state  = acp_pkg::ACP_IDLE;
                end
            end
        endcase
        // Switching the module off aborts any run
        if (!st_nxt.on) begin
            st_nxt.go    = 1'b0;
            st_nxt.state = acp_pkg::ACP_IDLE;
            st_nxt.core.start = 1'b0;
        end
        st_nxt.core.sample = st_nxt.on && st_nxt.state != acp_pkg::ACP_CONV;
        st_nxt.mask = pin_mask(st_nxt.pcfg);               // RL13
        // Register reads, data in the next cycle
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                acp_pkg::OFS_CTRL0:
                    st_nxt.rd = {st_r.cal, 1'b0, st_r.chs, st_r.go, st_r.on}; // RL9 RL8
                acp_pkg::OFS_PINREF:
                    st_nxt.rd = {2'h0, st_r.nref, st_r.pref, st_r.pcfg}; // RL12
                acp_pkg::OFS_TIMING:
                    st_nxt.rd = {st_r.just, 1'b0, st_r.acqt, st_r.adcs};
                acp_pkg::OFS_RESH:                         // RL2
                    st_nxt.rd = st_r.just ? {6'h00, st_r.result[9:8]}
                                          : st_r.result[9:2]; // RL17
                acp_pkg::OFS_RESL:
                    st_nxt.rd = st_r.just ? st_r.result[7:0]
                                          : {st_r.result[1:0], 6'h00}; // RL17
                acp_pkg::OFS_STATUS:
                    st_nxt.rd = {7'h00, st_r.done};
                default:
                    st_nxt.rd = 8'h00;                     // Unmapped reads zero
            endcase
        end
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;                                    // RL18
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data         = st_r.rd;
    assign core_o          = st_r.core;
    assign pin_analog_mask = st_r.mask;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_start_needs_on: assert property (core_o.start |-> st_r.on) // RL19
        else $error("start while module off");
    chk_go_reads_busy: assert property (bus_i.rd && bus_i.addr == acp_pkg::OFS_CTRL0
        && st_r.state != acp_pkg::ACP_IDLE |=> rd_data[1]) // RL8
        else $error("busy bit not read as one");
    chk_done_ends_run: assert property (st_r.state == acp_pkg::ACP_CONV && core_done
        && st_nxt.on |=> !st_r.go && st_r.done && st_r.result == $past(core_result)) // RL15
        else $error("completion not recorded");
    chk_bit6_zero: assert property (bus_i.rd && bus_i.addr == acp_pkg::OFS_CTRL0
        |=> rd_data[6] == 1'b0) // RL9
        else $error("control bit 6 not zero");
    chk_pinref_top: assert property (bus_i.rd && bus_i.addr == acp_pkg::OFS_PINREF
        |=> rd_data[7:6] == 2'h0) // RL12
        else $error("pin register top bits not zero");
    chk_manual_acq: assert property (bus_i.wr && bus_i.addr == acp_pkg::OFS_CTRL0
        && bus_i.wdata[1:0] == 2'h3 && st_r.state == acp_pkg::ACP_IDLE
        && st_r.acqt == 3'h0 |=> core_o.start) // RL16
        else $error("manual acquisition did not start at once");
    chk_auto_acq: assert property (bus_i.wr && bus_i.addr == acp_pkg::OFS_CTRL0
        && bus_i.wdata[1:0] == 2'h3 && st_r.state == acp_pkg::ACP_IDLE
        && st_r.acqt == 3'h1 && st_r.adcs == 3'h0
        |=> !core_o.start [*4] ##1 core_o.start) // RL16
        else $error("two-period acquisition wrong length");
    chk_bad_channel: assert property (core_o.start && core_o.channel > acp_pkg::CH_LAST
        |-> !core_o.ch_valid) // RL4
        else $error("absent channel marked valid");
    chk_all_digital: assert property (st_r.pcfg == 4'hF |-> pin_analog_mask == 13'h0000) // RL13
        else $error("all-digital code left analog pins");
    chk_right_just: assert property (bus_i.rd && bus_i.addr == acp_pkg::OFS_RESH
        && st_r.just |=> rd_data[7:2] == 6'h00) // RL17
        else $error("right justified high byte not padded");

    cov_manual_run: cover property (core_o.start ##[1:50] core_done);
    cov_auto_run:   cover property (st_r.state == acp_pkg::ACP_ACQ ##[1:300] core_o.start);
    cov_abort:      cover property (st_r.go ##1 !st_r.go && !st_r.on);
    cov_cal_run:    cover property (core_o.start && core_o.calibrate);
endmodule // acp_ctrl
`default_nettype wire

// File: acp_pkg.sv
//----------------------------------------------------------------
// Overview of operation
// RL1: Converts selected input to ten-bit unsigned result
// RL2: Three control registers plus result byte pair
// RL3: Channel field bits 5-2 selects inputs 0-12
// RL4: Codes 13-15 select nothing, conversion still runs
// RL5: Small package drops channels 5 to 7
// RL6: Calibrate bit makes next conversion calibrate
// RL7: Bit 0 enables the converter module
// RL8: Bit 1 reads one while converting
// RL9: Control zero bit 6 reads zero always
// RL10: Bit 5 picks negative reference source
// RL11: Bit 4 picks positive reference source
// RL12: Pin/reference register bits 7-6 read zero
// RL13: Pin field turns inputs digital from 12 down
// RL14: Fuse picks pin field reset 0000 or 0111
// RL15: Completion loads result, clears busy, sets flag
// RL16: Acquisition code 000 starts immediately, else waits
// RL17: Justify bit right-aligns result when one
// RL18: Reset turns module off, aborts conversion
// RL19: Start ignored while module is off
// RL20: Software keeps settings still while converting
//----------------------------------------------------------------
package acp_pkg;
    localparam int          ADDR_W     = 3;               // Register address width
    localparam logic [2:0]  OFS_CTRL0  = 3'h0;            // Control zero
    localparam logic [2:0]  OFS_PINREF = 3'h1;            // Pin and reference
    localparam logic [2:0]  OFS_TIMING = 3'h2;            // Timing control
    localparam logic [2:0]  OFS_RESH   = 3'h3;            // Result high byte
    localparam logic [2:0]  OFS_RESL   = 3'h4;            // Result low byte
    localparam logic [2:0]  OFS_STATUS = 3'h5;            // Done flag
    localparam int          B_CAL      = 7;               // Calibrate next
    localparam int          B_GO       = 1;               // Conversion busy
    localparam int          B_ON       = 0;               // Module enable
    localparam int          B_NREF     = 5;               // Negative reference
    localparam int          B_PREF     = 4;               // Positive reference
    localparam int          B_JUST     = 7;               // Result justify
    localparam logic [3:0]  PCFG_FUSE1 = 4'h0;            // Pin field, fuse one
    localparam logic [3:0]  PCFG_FUSE0 = 4'h7;            // Pin field, fuse zero
    localparam logic [3:0]  CH_LAST    = 4'hC;            // Highest real channel
    localparam logic [3:0]  PCFG_ALLA  = 4'h2;            // Last all-analog code
    localparam logic [1:0]  FUSE_WAIT  = 2'h2;            // Sync depth before load
    localparam int          FRC_NS     = 500;             // Internal RC bit period
    localparam int          CLK_NS     = 5;               // System clock period
    localparam logic [6:0]  FRC_CYC    = 7'((FRC_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {ACP_IDLE, ACP_ACQ, ACP_CONV} acp_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;                          // Register address
        logic [7:0]        wdata;                         // Write data
        logic              wr;                            // Write strobe
        logic              rd;                            // Read strobe
    } acp_bus_t;

    typedef struct packed {
        logic       start;                                // Start pulse
        logic       calibrate;                            // Calibrate this run
        logic [3:0] channel;                              // Channel to route
        logic       ch_valid;                             // Channel exists
        logic       neg_ref_ext;                          // External negative ref
        logic       pos_ref_ext;                          // External positive ref
        logic       sample;                               // Hold cap tracking
    } acp_core_t;
endpackage

// File: acp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Converter core stand-in: answers every start after a delay
// ----------------------------------------------------------------
module acp_core_model (
    input  wire logic               clk_sys,      // System clock
    input  wire logic               rst,          // Async reset, high
    input  wire acp_pkg::acp_core_t core_i,       // Controls from block
    input  wire logic               slow,         // Long conversion
    input  wire logic [9:0]         next_val,     // Value to return
    output var  logic               core_done,    // Finish pulse
    output var  logic [9:0]         core_result   // Result, valid with done
);
    logic [5:0] cnt_r;                            // Cycles left in run
    logic [9:0] last_r;                           // Pattern shown when idle
    // Count a run down, pulse done at its end, never hold the result
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r       <= 6'h00;                 // Reset aborts a run
            core_done   <= 1'b0;
            core_result <= 10'h000;
            last_r      <= 10'h155;
        end else begin
            core_done   <= 1'b0;
            last_r      <= ~last_r;
            core_result <= last_r;                // Changes every cycle
            if (core_i.start) begin
                cnt_r <= slow ? 6'h1E : 6'h03;
            end else if (cnt_r == 6'h01) begin
                cnt_r       <= 6'h00;
                core_done   <= 1'b1;
                core_result <= core_i.ch_valid ? next_val : ~last_r;
            end else if (cnt_r != 6'h00) begin
                cnt_r <= cnt_r - 6'h01;
            end
        end
    end
endmodule // acp_core_model
`default_nettype wire

// File: acp_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module acp_ctrl_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic               clk_sys, rst, fuse_pin, slow;   // Drives
    acp_pkg::acp_bus_t  bus_i;                          // Register request
    logic [7:0]         rd_data, d, d2;                 // Read data
    logic               core_done;                      // Core finish
    logic [9:0]         core_result, next_val, res;     // Results
    acp_pkg::acp_core_t core_o, small_core, cap, s_cap; // Core controls
    logic [12:0]        pin_analog_mask, small_mask;    // Pin masks
    logic [31:0]        r;                              // Random draw
    logic [3:0]         ch;                             // Channel code
    int                 n_errors, tests_run, seed, k;   // Bookkeeping
    int                 acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    // ------------------------------------------------------------
    // Design, small-package copy and core model
    // ------------------------------------------------------------
    acp_ctrl #(.LARGE_PKG(1'b1)) acp_ctrl_i (.clk_sys(clk_sys), .rst(rst),
        .bus_i(bus_i), .rd_data(rd_data), .fuse_pin(fuse_pin), .core_done(core_done),
        .core_result(core_result), .core_o(core_o), .pin_analog_mask(pin_analog_mask));
    acp_ctrl #(.LARGE_PKG(1'b0)) acp_ctrl_s_i (.clk_sys(clk_sys), .rst(rst),
        .bus_i(bus_i), .rd_data(), .fuse_pin(fuse_pin), .core_done(core_done),
        .core_result(core_result), .core_o(small_core), .pin_analog_mask(small_mask));
    acp_core_model acp_core_model_i (.clk_sys(clk_sys), .rst(rst), .core_i(core_o),
        .slow(slow), .next_val(next_val), .core_done(core_done), .core_result(core_result));
    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #50000;                                        // Ten times the expected run
        n_errors++;
        test_done();
    end
    // ------------------------------------------------------------
    // Tasks and expectation functions
    // ------------------------------------------------------------
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus_i.addr  <= a;
        bus_i.wdata <= v;
        bus_i.wr    <= 1'b1;
        @(posedge clk_sys);
        bus_i.wr    <= 1'b0;
    endtask
    task automatic bus_rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        bus_i.addr <= a;
        bus_i.rd   <= 1'b1;
        @(posedge clk_sys);
        bus_i.rd   <= 1'b0;
        #1 v = rd_data;                                // Only cycle it stands
    endtask
    // Cycle index of the start pulse after a write edge, 0 if none
    task automatic wait_start(output int kk);
        kk = 0;
        for (int i = 1; i <= 60 && kk == 0; i++) begin
            #1;
            if (core_o.start === 1'b1) begin
                kk    = i;
                cap   = core_o;
                s_cap = small_core;
            end else begin
                @(posedge clk_sys);
            end
        end
    endtask
    task automatic wait_done();
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys);
            if (core_done === 1'b1) begin
                res = core_result;
                break;
            end
        end
    endtask
    task automatic reset_dut(input logic f);
        rst      <= 1'b1;
        fuse_pin <= f;
        repeat (4) @(posedge clk_sys);
        rst      <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    function automatic logic [12:0] exp_mask(input logic [3:0] c);
        return (c <= 4'h2) ? 13'h1FFF : 13'h1FFF >> (c - 4'h2);
    endfunction
    // Register pair view of a result: right or left aligned
    function automatic logic [15:0] exp_res(input logic [9:0] v, input logic j);
        return j ? {6'h00, v} : {v, 6'h00};
    endfunction
    task automatic test_done();
        $display("Counts: tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        fuse_pin = 1'b0;
        slow = 1'b1;
        bus_i = '0;
        next_val = 10'h000;
        seed = 32'h0BA40B1C;
        n_errors = 0;
        tests_run = 0;
        reset_dut(1'b0);
        bus_rd(acp_pkg::OFS_CTRL0, d);
        chk_reg(d, 8'h00);
        bus_rd(acp_pkg::OFS_PINREF, d);
        chk_reg(d, 8'h07);
        chk_sig(16'(pin_analog_mask), 16'h00FF);
        $display("Test reset values finished");
        // Every channel, pin and acquisition code with random settings
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            ch = 4'(i);
            next_val <= r[9:0];
            slow     <= r[23];
            bus_wr(acp_pkg::OFS_PINREF, {r[31:28], ch});
            bus_rd(acp_pkg::OFS_PINREF, d);
            chk_reg(d, {2'b00, r[29:28], ch});
            chk_sig(16'(pin_analog_mask), 16'(exp_mask(ch)));
            chk_sig(16'(small_mask), 16'(exp_mask(ch) & 13'h1F1F));
            bus_wr(acp_pkg::OFS_TIMING, {r[27:26], 3'(i), 3'h0});
            bus_wr(acp_pkg::OFS_CTRL0, {r[25:24], ch, 2'b11});
            wait_start(k);
            chk_sig(16'(k), 16'((i % 8 == 0) ? 1 : 2 * acq_tab[i % 8] + 1));
            chk_sig(16'({cap.channel, cap.ch_valid, cap.calibrate, cap.neg_ref_ext,
                cap.pos_ref_ext, cap.sample}), 16'({ch, ch <= 4'hC, r[25], r[29:28], 1'b0}));
            chk_sig(16'(s_cap.ch_valid), 16'(ch <= 4'hC && (ch < 4'h5 || ch > 4'h7)));
            bus_rd(acp_pkg::OFS_CTRL0, d);
            chk_reg(d, {r[25], 1'b0, ch, 2'b11});
            wait_done();
            bus_rd(acp_pkg::OFS_CTRL0, d);
            chk_reg(d, {r[25], 1'b0, ch, 2'b01});
            chk_sig(16'(core_o.sample), 16'h0001);
            bus_rd(acp_pkg::OFS_RESH, d);
            bus_rd(acp_pkg::OFS_RESL, d2);
            chk_sig({d, d2}, exp_res(res, r[27]));
            bus_rd(acp_pkg::OFS_STATUS, d);
            chk_reg(d, 8'h01);
            bus_wr(acp_pkg::OFS_STATUS, 8'h01);
            bus_rd(acp_pkg::OFS_STATUS, d);
            chk_reg(d, 8'h00);
        end
        $display("Test conversions finished");
        // Result bytes are read only, unmapped places read zero
        bus_wr(acp_pkg::OFS_RESH, 8'hFF);
        bus_wr(acp_pkg::OFS_RESL, 8'hFF);
        bus_wr(3'h6, 8'hFF);
        bus_rd(acp_pkg::OFS_RESH, d);
        bus_rd(acp_pkg::OFS_RESL, d2);
        chk_sig({d, d2}, exp_res(res, r[27]));
        bus_rd(3'h6, d);
        chk_reg(d, 8'h00);
        bus_rd(3'h7, d);
        chk_reg(d, 8'h00);
        // Start request while the module is off
        bus_wr(acp_pkg::OFS_CTRL0, 8'h02);
        wait_start(k);
        chk_sig(16'(k), 16'h0000);
        $display("Test refusals finished");
        // Reset in mid-conversion, fuse now set
        bus_wr(acp_pkg::OFS_CTRL0, 8'h03);
        wait_start(k);
        chk_sig(16'(k), 16'h0029);
        reset_dut(1'b1);
        bus_rd(acp_pkg::OFS_CTRL0, d);
        chk_reg(d, 8'h00);
        bus_rd(acp_pkg::OFS_PINREF, d);
        chk_reg(d, 8'h00);
        chk_sig(16'(pin_analog_mask), 16'h1FFF);
        bus_rd(acp_pkg::OFS_STATUS, d);
        chk_reg(d, 8'h00);
        $display("Test abort by reset finished");
        // Switching the module off mid-run aborts it; the late finish is ignored
        bus_wr(acp_pkg::OFS_CTRL0, 8'h03);
        wait_start(k);
        chk_sig(16'(k), 16'h0001);
        bus_wr(acp_pkg::OFS_CTRL0, 8'h00);
        bus_rd(acp_pkg::OFS_CTRL0, d);
        chk_reg(d, 8'h00);
        wait_done();
        bus_rd(acp_pkg::OFS_STATUS, d);
        chk_reg(d, 8'h00);
        $display("Test abort by switch-off finished");
        test_done();
    end
endmodule // acp_ctrl_tb_top
`default_nettype wire
